// ==== rtl/psm_ctrl.sv ====
// Power saving mode controller: strap pin, power mode control register,
// idle and power down entry, slow-down clock enables and watchdog start.
// Assumes a classic Wishbone slave port on the 100 MHz clock and a strap
// level that is already synchronous to that clock.
`default_nettype none

module psm_ctrl
(
    input  wire logic        clk,         // 100 MHz clock
    input  wire logic        reset,       // Asynchronous reset, active high
    input  wire logic        clk_en,      // Freezes all state but the reset strap and watchdog latch while low
    // Classic Wishbone slave.
    input  wire logic        wb_cyc_i,    // Cycle
    input  wire logic        wb_stb_i,    // Strobe
    input  wire logic        wb_we_i,     // Write enable
    input  wire logic [7:0]  wb_adr_i,    // Byte address
    input  wire logic [3:0]  wb_sel_i,    // Byte lanes
    input  wire logic [31:0] wb_dat_i,    // Write data
    output logic      [31:0] wb_dat_o,    // Read data
    output logic             wb_ack_o,    // Acknowledge
    // Pins and system.
    input  wire logic        power_save_block_strap, // High blocks modes
    input  wire logic        irq_pending, // Any enabled interrupt
    output logic             watchdog_autostart, // Watchdog self-start
    output psm_pkg::psm_gates_s gates,    // Clock and pin controls
    output logic             machine_tick, // One pulse per machine cycle
    output logic             halt_active, // Idle mode active
    output logic             pdown_active // Power down active
);

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic       req;
    logic       hit;
    logic       wr_strobe;
    logic [7:0] wr_byte;

    // Decode a register address against a printed offset.
    function automatic logic addr_hit(input logic [7:0] adr,
                                      input logic [7:0] off);
        addr_hit = (adr == off);
    endfunction

    assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign hit       = addr_hit(wb_adr_i, psm_pkg::PSM_PMC_OFFSET);
    assign wr_strobe = req && wb_we_i && hit && wb_sel_i[0] && clk_en;
    assign wr_byte   = wb_dat_i[7:0];

    // Ack one cycle after the request; unmapped reads return zero.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            wb_ack_o <= 1'b0;
        else if (clk_en)
            wb_ack_o <= req;
    end

    // ****************************************************************
    // Machine cycle timing
    // ****************************************************************
    logic [3:0] phase_reg;
    logic [2:0] slow_reg;
    logic       osc_tick;

    assign osc_tick = (phase_reg == psm_pkg::PSM_LAST_PHASE);

    // Phase counter runs on the oscillator; power down stops it.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            phase_reg <= 4'h0;
        else if (clk_en && !pdown_active)
            phase_reg <= osc_tick ? 4'h0 : phase_reg + 4'h1;
    end

    logic div_en_reg;
    logic div_eff_reg;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            slow_reg    <= 3'h0;
            div_eff_reg <= 1'b0;
        end
        else if (clk_en && osc_tick)
        begin
            // The new rate is latched at a machine cycle boundary, so
            // it takes effect within one or two machine cycles.
            if (slow_reg == 3'h0)
                div_eff_reg <= div_en_reg;
            slow_reg <= (div_eff_reg && slow_reg != psm_pkg::PSM_SLOW_LAST)
                        ? slow_reg + 3'h1 : 3'h0;
        end
    end

    assign machine_tick = osc_tick && (slow_reg == 3'h0) && !pdown_active;

    // ****************************************************************
    // Strap sampling
    // ****************************************************************
    logic strap_reg;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            strap_reg <= 1'b1;
        else if (clk_en && phase_reg == psm_pkg::PSM_SAMPLE_PH)
            strap_reg <= power_save_block_strap;
    end

    // reset strap
    // Caught on clock edges during reset; asynchronous reset does not
    // touch it, so a low level at any edge during reset decides.
    logic strap_low_seen_reg;
    logic in_reset_reg;
    always_ff @(posedge clk)
    begin
        in_reset_reg <= reset;
        if (reset)
        begin
            // The first edge of a reset reloads and later edges collect;
            // an unknown history at power-up also takes the reload path.
            if (in_reset_reg)
                strap_low_seen_reg <= strap_low_seen_reg
                                      || !power_save_block_strap;
            else
                strap_low_seen_reg <= !power_save_block_strap;
        end
    end

    // watchdog latch
    // Loaded only at the first edge after release, never again.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            watchdog_autostart <= 1'b0;
        else if (in_reset_reg)
            watchdog_autostart <= !strap_low_seen_reg;
    end

    // ****************************************************************
    // Power mode control register
    // ****************************************************************
    logic [7:0] store_reg;
    logic       halt_arm_reg;
    logic       pd_arm_reg;
    logic       halt_go;
    logic       pd_go;
    logic       blocked;

    assign blocked = strap_reg;

    assign halt_go = wr_strobe && halt_arm_reg && !blocked
                     && wr_byte[psm_pkg::PSM_BIT_HALT_GO]
                     && !wr_byte[psm_pkg::PSM_BIT_HALT_ARM];
    assign pd_go   = wr_strobe && pd_arm_reg && !blocked
                     && wr_byte[psm_pkg::PSM_BIT_PD_GO]
                     && !wr_byte[psm_pkg::PSM_BIT_PD_ARM];

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            store_reg <= psm_pkg::PSM_PMC_RESET;
        else if (wr_strobe)
            store_reg <= wr_byte & psm_pkg::PSM_STORE_MASK;
    end
    assign div_en_reg = store_reg[psm_pkg::PSM_BIT_DIV_EN];

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            halt_arm_reg <= 1'b0;
            pd_arm_reg   <= 1'b0;
        end
        else if (wr_strobe)
        begin
            halt_arm_reg <= wr_byte[psm_pkg::PSM_BIT_HALT_ARM]
                            && !wr_byte[psm_pkg::PSM_BIT_HALT_GO];
            pd_arm_reg   <= wr_byte[psm_pkg::PSM_BIT_PD_ARM]
                            && !wr_byte[psm_pkg::PSM_BIT_PD_GO];
        end
    end

    // Read data: arm and start bits always read zero.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            wb_dat_o <= 32'h0000_0000;
        else if (clk_en)
            wb_dat_o <= (req && hit && !wb_we_i)
                        ? {24'h00_0000, store_reg}
                        : {24'h00_0000, psm_pkg::PSM_READ_ZERO};
    end

    // ****************************************************************
    // Mode sequencer
    // ****************************************************************
    psm_pkg::psm_mode_e mode_reg;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            mode_reg <= psm_pkg::PSM_RUN;
        else if (clk_en)
        begin
            case (mode_reg)
                psm_pkg::PSM_RUN:
                    if (pd_go)
                        mode_reg <= psm_pkg::PSM_PDOWN;
                    else if (halt_go)
                        mode_reg <= psm_pkg::PSM_HALT;
                psm_pkg::PSM_HALT:
                    if (irq_pending)
                        mode_reg <= psm_pkg::PSM_RUN;
                default:
                    mode_reg <= mode_reg;
            endcase
        end
    end

    assign halt_active  = (mode_reg == psm_pkg::PSM_HALT);
    assign pdown_active = (mode_reg == psm_pkg::PSM_PDOWN);

    always_comb
    begin
        gates.cpu_clk_en     = !halt_active && !pdown_active;
        gates.periph_clk_en  = !pdown_active;
        gates.wdog_clk_en    = !halt_active && !pdown_active;
        gates.osc_run        = !pdown_active;
        gates.strobe_hold_hi = halt_active;
        gates.strobe_hold_lo = pdown_active;
        gates.hold_cpu_state = halt_active || pdown_active;
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    // blocked entry
    strap_blocks_a: assert property (@(posedge clk) disable iff (reset)
        (blocked && mode_reg == psm_pkg::PSM_RUN) |=>
        mode_reg == psm_pkg::PSM_RUN)
        else $error("Mode entered while strap high");

    pd_wins_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && pd_go && mode_reg == psm_pkg::PSM_RUN) |=> pdown_active)
        else $error("Power down did not win");

    joint_write_a: assert property (@(posedge clk) disable iff (reset)
        (wr_strobe && wr_byte[psm_pkg::PSM_BIT_HALT_ARM]
         && mode_reg == psm_pkg::PSM_RUN) |=> !halt_active)
        else $error("Joint write started idle");

    arm_reads_a: assert property (@(posedge clk) disable iff (reset)
        wb_ack_o |-> (wb_dat_o[1:0] == 2'b00 && wb_dat_o[6:5] == 2'b00))
        else $error("Arm or start bit read nonzero");

    pd_sticky_a: assert property (@(posedge clk) disable iff (reset)
        pdown_active |=> pdown_active)
        else $error("Power down left without reset");

    irq_wake_a: assert property (@(posedge clk) disable iff (reset)
        (halt_active && irq_pending && clk_en) |=> !halt_active)
        else $error("Interrupt did not end idle");

    idle_gates_a: assert property (@(posedge clk) disable iff (reset)
        halt_active |-> (!gates.cpu_clk_en && gates.periph_clk_en
                         && !gates.wdog_clk_en))
        else $error("Idle clock gating wrong");

    arm_discard_a: assert property (@(posedge clk) disable iff (reset)
        (wr_strobe && !wr_byte[psm_pkg::PSM_BIT_HALT_ARM]) |=>
        !halt_arm_reg)
        else $error("Arm state not discarded");

    wdog_steady_a: assert property (@(posedge clk) disable iff (reset)
        !in_reset_reg |=> $stable(watchdog_autostart))
        else $error("Watchdog start changed");

    flag_store_a: assert property (@(posedge clk) disable iff (reset)
        wr_strobe |=> store_reg[3:2] == $past(wr_byte[3:2]))
        else $error("Spare flags not stored");

    autostart_load_a: assert property (@(posedge clk) disable iff (reset)
        in_reset_reg |=> watchdog_autostart == !$past(strap_low_seen_reg))
        else $error("Watchdog start not loaded from strap");

    halt_armed_a: assert property (@(posedge clk) disable iff (reset)
        $rose(halt_active) |-> ($past(halt_arm_reg) && !$past(blocked)))
        else $error("Idle entered without arm or while blocked");

    pd_armed_a: assert property (@(posedge clk) disable iff (reset)
        $rose(pdown_active) |-> $past(pd_arm_reg))
        else $error("Power down entered without arm");

    pd_unblocked_a: assert property (@(posedge clk) disable iff (reset)
        $rose(pdown_active) |-> !$past(blocked))
        else $error("Power down entered while strap high");

    reset_exit_a: assert property (@(posedge clk)
        $fell(reset) |-> (mode_reg == psm_pkg::PSM_RUN))
        else $error("Mode not cleared by reset");

    idle_entry_c: cover property (@(posedge clk) disable iff (reset)
        halt_go ##1 halt_active);
    pd_entry_c: cover property (@(posedge clk) disable iff (reset)
        pd_go ##1 pdown_active);
    idle_wake_c: cover property (@(posedge clk) disable iff (reset)
        halt_active ##1 !halt_active);
    slow_mode_c: cover property (@(posedge clk) disable iff (reset)
        div_eff_reg && machine_tick);

endmodule

`default_nettype wire

// ==== rtl/psm_pkg.sv ====
// Package for the power saving mode controller: register map, field
// positions, reset values, timing constants and carrier types.
// Assumes a 100 MHz clock and a classic Wishbone register bus.
`default_nettype none

package psm_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] PSM_PMC_OFFSET = 8'h87;
    localparam logic [7:0] PSM_PMC_RESET  = 8'h00;
    localparam logic [7:0] PSM_READ_ZERO  = 8'h00;

    // Bit positions of the power mode control register.
    localparam int PSM_BIT_HALT_ARM  = 0;
    localparam int PSM_BIT_PD_ARM    = 1;
    localparam int PSM_BIT_FLAG0     = 2;
    localparam int PSM_BIT_FLAG1     = 3;
    localparam int PSM_BIT_DIV_EN    = 4;
    localparam int PSM_BIT_HALT_GO   = 5;
    localparam int PSM_BIT_PD_GO     = 6;

    // Bits that store and read back as written.
    localparam logic [7:0] PSM_STORE_MASK = 8'h1C;

    // ****************************************************************
    // Timing
    // ****************************************************************
    // Oscillator periods per machine cycle, states per cycle.
    localparam logic [3:0] PSM_PHASES      = 4'hC;
    localparam logic [3:0] PSM_LAST_PHASE  = 4'hB;
    // State 3 phase 1 is the fifth oscillator period (index 4).
    localparam logic [3:0] PSM_SAMPLE_PH   = 4'h4;
    // Slow-down divides the machine cycle rate by eight.
    localparam logic [2:0] PSM_SLOW_LAST   = 3'h7;
    // Slow-down takes effect within two machine cycles.
    localparam int PSM_SLOW_SYNC_CYC       = 2;

    typedef enum logic [1:0] {
        PSM_RUN,
        PSM_HALT,
        PSM_PDOWN
    } psm_mode_e;

    // Status gathered for the core and peripherals.
    typedef struct packed {
        logic cpu_clk_en;     // CPU clock gate
        logic periph_clk_en;  // Peripheral clock gate
        logic wdog_clk_en;    // Watchdog clock gate
        logic osc_run;        // Oscillators running
        logic strobe_hold_hi; // Address latch/program strobe high
        logic strobe_hold_lo; // Strobes low in power down
        logic hold_cpu_state; // CPU registers frozen
    } psm_gates_s;

endpackage

`default_nettype wire

// ==== sim/psm_far_model.sv ====
// Far-side model: the power-fail circuit on the strap pin and the
// source of enabled interrupts. Assumes the bench asks for levels on clk.
`default_nettype none

module psm_far_model
(
    input  wire logic clk,          // System clock
    input  wire logic strap_req,    // Strap level the bench asks for
    input  wire logic irq_req,      // Interrupt the bench asks for
    input  wire logic pdown_active, // Power down from the block
    output logic      strap,        // Strap pin level
    output logic      irq           // Enabled interrupt pending
);
    timeunit 1ns;
    timeprecision 1ps;

    // The pin idles high, as the weak pull-up would leave it.
    initial
    begin
        strap = 1'b1;
        irq   = 1'b0;
    end

    // strap held high
    // A falling strap in power down would end it irregularly, so the
    // circuit keeps the pin high until power down has been left.
    always @(posedge clk)
    begin
        if (!(pdown_active && strap && !strap_req))
            strap <= strap_req;
        irq <= irq_req;
    end
endmodule

`default_nettype wire

// ==== sim/tb_power_saving_mode_control.sv ====
// Testbench for the power saving mode controller: Wishbone tasks, a
// far-side model for strap and interrupt, and queued read checks.
// Assumes the design package and the far-side model compile first.
`default_nettype none

module tb_power_saving_mode_control;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Signals
    // ****************************************************************
    localparam logic [7:0] A    = psm_pkg::PSM_PMC_OFFSET;
    // Gate vectors, msb first: cpu, periph, wdog, osc, hi, lo, hold.
    localparam logic [6:0] RUN_G = 7'h78;
    localparam logic [6:0] IDL_G = 7'h2D;
    localparam logic [6:0] PD_G  = 7'h03;
    localparam int         PH    = int'(psm_pkg::PSM_PHASES);
    logic                  clk, reset, clk_en, wb_cyc, wb_stb, wb_we;
    logic [7:0]            wb_adr;
    logic [3:0]            wb_sel, sel_v;
    logic [31:0]           wb_dat_w, wb_dat_r;
    logic                  wb_ack, strap_req, irq_req, strap, irq;
    logic                  watchdog_autostart, machine_tick;
    logic                  halt_active, pdown_active;
    psm_pkg::psm_gates_s   gates;
    logic [31:0]           rd_q[$];
    int                    error_cnt, tests_run;

    psm_ctrl dut
    (
        .clk(clk), .reset(reset), .clk_en(clk_en), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
        .wb_ack_o(wb_ack), .power_save_block_strap(strap),
        .irq_pending(irq), .watchdog_autostart(watchdog_autostart),
        .gates(gates), .machine_tick(machine_tick),
        .halt_active(halt_active), .pdown_active(pdown_active)
    );

    psm_far_model far
    (
        .clk(clk), .strap_req(strap_req), .irq_req(irq_req),
        .pdown_active(pdown_active), .strap(strap), .irq(irq)
    );

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict;
        if (error_cnt == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb_cycle(input logic we, input logic [7:0] adr,
                            input logic [7:0] dat);
        @(posedge clk);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= adr;
        wb_sel   <= sel_v;
        wb_dat_w <= {24'h000000, dat};
        // Waits as long as the slave needs; the watchdog ends a hang.
        do
            @(posedge clk);
        while (wb_ack !== 1'b1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        wb_cycle(1'b1, adr, d);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [7:0] e);
        rd_q.push_back({24'h000000, e});
        wb_cycle(1'b0, adr, 8'h00);
    endtask

    task automatic try_seq(input logic [7:0] a, b, input logic h, p);
        wr(A, a);
        wr(A, b);
        @(posedge clk);
        check("halt_active", halt_active, h);
        check("pdown_active", pdown_active, p);
    endtask

    // Period between two machine ticks, in clocks.
    task automatic tick_gap(output int gap);
        int w;
        w = 0;
        do @(posedge clk); while (machine_tick !== 1'b1 && ++w < 200);
        gap = 0;
        do
        begin
            @(posedge clk);
            gap++;
        end
        while (machine_tick !== 1'b1 && gap < 200);
    endtask

    // ****************************************************************
    // Clock, monitor, watchdog
    // ****************************************************************
    always #5 clk = ~clk;

    // Reads take the oldest expectation when ack is seen.
    always @(posedge clk)
        if (wb_ack === 1'b1 && wb_we === 1'b0 && rd_q.size() > 0)
            check("read data", wb_dat_r, rd_q.pop_front());

    // The tests need a few hundred clocks; this cuts a hang short.
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        logic [7:0] tbl [4][2];
        logic [7:0] d;
        int         g;
        tbl = '{'{8'h21, 8'h00}, '{8'h00, 8'h40},
                '{8'h01, 8'h0C}, '{8'h20, 8'h00}};
        clk = 1'b0; reset = 1'b1; clk_en = 1'b1; wb_cyc = 1'b0;
        wb_stb = 1'b0; wb_we = 1'b0; wb_adr = 8'h00; wb_sel = 4'hF;
        sel_v = 4'hF; wb_dat_w = '0; strap_req = 1'b1; irq_req = 1'b0;
        error_cnt = 0;
        tests_run = 0;
        d = 8'($urandom(24));
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        check("autostart", watchdog_autostart, 1'b1);
        check("gates", gates, RUN_G);
        rd(A, 8'h00);
        repeat (2 * PH) @(posedge clk);
        try_seq(8'h01, 8'h20, 1'b0, 1'b0);
        try_seq(8'h02, 8'h40, 1'b0, 1'b0);
        strap_req <= 1'b0;
        repeat (2 * PH) @(posedge clk);
        check("autostart", watchdog_autostart, 1'b1);
        for (int i = 0; i < 4; i++)
            try_seq(tbl[i][0], tbl[i][1], 1'b0, 1'b0);
        rd(A, 8'h00);
        repeat (4)
        begin
            d = 8'($urandom()) & 8'h9C;
            wr(A, d);
            rd(A, d & psm_pkg::PSM_STORE_MASK);
        end
        wr(A, 8'h00);
        wr(8'h86, 8'h1C);
        rd(8'h86, 8'h00);
        sel_v = 4'hE;
        wr(A, 8'h1C);
        sel_v = 4'hF;
        rd(A, 8'h00);
        wr(A, 8'h10);
        tick_gap(g);
        tick_gap(g);
        check("slow gap", g, PH * (int'(psm_pkg::PSM_SLOW_LAST) + 1));
        wr(A, 8'h00);
        tick_gap(g);
        tick_gap(g);
        check("normal gap", g, PH);
        wr(A, 8'h01);
        wr(A, 8'h2C);
        @(posedge clk);
        check("halt_active", halt_active, 1'b1);
        check("gates", gates, IDL_G);
        rd(A, 8'h0C);
        irq_req <= 1'b1;
        repeat (3) @(posedge clk);
        check("halt_active", halt_active, 1'b0);
        irq_req <= 1'b0;
        try_seq(8'h03, 8'h60, 1'b0, 1'b1);
        check("gates", gates, PD_G);
        irq_req <= 1'b1;
        repeat (30) @(posedge clk);
        check("pdown_active", pdown_active, 1'b1);
        irq_req <= 1'b0;
        reset <= 1'b1;
        repeat (2 * PH) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        check("pdown_active", pdown_active, 1'b0);
        check("autostart", watchdog_autostart, 1'b0);
        rd(A, 8'h00);
        repeat (2) @(posedge clk);
        print_verdict();
    end
endmodule

`default_nettype wire
